// ==== bench/status_reset_assertions.sv ====
// Concurrent checks on the status and reset block ports
`timescale 1ns/1ps
module status_reset_checker #(
  parameter int unsigned SHORT_CYC = 20,
  parameter int unsigned LONG_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [11:0] cfg_word,
  input wire logic reset_pin_raw,
  input wire logic wdt_timeout,
  input wire logic pin_change_wake,
  input wire logic comp_change_wake,
  input wire logic core_sleeping,
  input wire logic core_status_we,
  input wire logic core_alu_we,
  input wire status_reset_pkg::alu_flags_t core_alu_flags,
  input wire logic [7:0] status_out,
  input wire logic core_reset_out,
  input wire logic reset_pin_gpio_out,
  input wire logic int_osc_fast_out,
  input wire logic clock_out_en_out,
  input wire logic [2:0] osc_kind_out
);
  // ----
  // Helpers
  // ----
  logic [2:0] hi_cnt;
  logic [31:0] hold_cnt;
  logic calm;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hi_cnt <= 3'h0;
    else if (!reset_pin_raw) hi_cnt <= 3'h0;
    else if (hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hold_cnt <= 32'h0;
    else if (core_reset_out) hold_cnt <= hold_cnt + 32'h1;
    else hold_cnt <= 32'h0;
  end
  assign calm = hi_cnt[2] && !wdt_timeout;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----
  // Checks
  // ----
  chk_prot_flags: assert property (
    (core_status_we || avs_write && !avs_waitrequest && avs_address == 4'h3) && calm
    && !pin_change_wake && !comp_change_wake |=> $stable(status_out[4:3]))
    else $error("protected flag moved on a write");
  chk_alu_flags: assert property (
    core_alu_we && calm |=> status_out[2:0] == $past(core_alu_flags))
    else $error("arithmetic flags not from result");
  chk_wdt_sleep: assert property (
    wdt_timeout && core_sleeping && hi_cnt[2] |=> status_out[7:6] == 2'h0
    && status_out[4:3] == 2'h0) else $error("watchdog wake flags wrong");
  chk_wdt_run: assert property (
    wdt_timeout && !core_sleeping && hi_cnt[2] |=> status_out[7:6] == 2'h0
    && !status_out[4] && status_out[3] == $past(status_out[3]))
    else $error("watchdog run flags wrong");
  chk_change_wake: assert property (
    pin_change_wake && core_sleeping && calm |=> status_out[7:6] == 2'h2
    && status_out[4:3] == 2'h2) else $error("pin change wake flags wrong");
  chk_comp_wake: assert property (
    comp_change_wake && !pin_change_wake && core_sleeping && calm
    |=> status_out[7:6] == 2'h1 && status_out[4:3] == 2'h2)
    else $error("comparator wake flags wrong");
  chk_cfg_outputs: assert property (
    !core_reset_out |-> int_osc_fast_out == cfg_word[6] && osc_kind_out == cfg_word[2:0]
    && clock_out_en_out == (cfg_word[2:0] == 3'h5 || cfg_word[2:0] == 3'h7))
    else $error("configuration decode wrong");
  chk_gpio_low: assert property (
    !core_reset_out && cfg_word[5] |-> !reset_pin_gpio_out)
    else $error("reset pin seen as input");
  chk_hold_len: assert property (
    $fell(core_reset_out) |-> hold_cnt >= (cfg_word[2:0] < 3'h3 ? LONG_CYC : SHORT_CYC))
    else $error("core released too early");
endmodule

// ==== bench/status_reset_logic_tb.sv ====
// Self-checking bench of the status and reset block
`timescale 1ns/1ps
module status_reset_logic_tb;
  localparam int unsigned SHORT = 20;
  localparam int unsigned LONG = 50;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, core_sleeping;
  logic core_status_we, core_alu_we, reset_pin_raw, wdt_timeout, pin_change_wake;
  logic comp_change_wake, core_reset_out, reset_pin_gpio_out, int_osc_fast_out;
  logic clock_out_en_out;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [11:0] cfg_word;
  logic [7:0] core_status_wdata, status_out;
  logic [2:0] osc_kind_out;
  status_reset_pkg::alu_flags_t core_alu_flags;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  status_reset_logic #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cfg_word(cfg_word), .reset_pin_raw(reset_pin_raw),
    .wdt_timeout(wdt_timeout), .pin_change_wake(pin_change_wake),
    .comp_change_wake(comp_change_wake), .core_sleeping(core_sleeping),
    .core_status_we(core_status_we), .core_status_wdata(core_status_wdata),
    .core_alu_we(core_alu_we), .core_alu_flags(core_alu_flags), .status_out(status_out),
    .core_reset_out(core_reset_out), .reset_pin_gpio_out(reset_pin_gpio_out),
    .int_osc_fast_out(int_osc_fast_out), .clock_out_en_out(clock_out_en_out),
    .osc_kind_out(osc_kind_out));
  wake_source_model src (.clk_sys(clk_sys), .reset_pin_raw(reset_pin_raw),
    .wdt_timeout(wdt_timeout), .pin_change_wake(pin_change_wake),
    .comp_change_wake(comp_change_wake));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_config;
    int n;
    int lim;
    for (int k = 0; k < 8; k++) begin
      rst_n <= 1'b0;
      cfg_word <= {5'h1f, k[0], k[1], 2'h3, k[2:0]};
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      check("status_por", 5'h03, status_out[7:3]);
      lim = k < 3 ? LONG : SHORT;
      n = 0;
      while (core_reset_out !== 1'b0 && n < 200) begin
        @(posedge clk_sys);
        n++;
      end
      check("hold_len", 1'b1, n >= lim && n <= lim + 4);
      check("osc_kind", k, osc_kind_out);
      check("clk_out", k == 5 || k == 7, clock_out_en_out);
      check("osc_fast", k[0], int_osc_fast_out);
      src.pin_set(1'b0);
      repeat (6) @(posedge clk_sys);
      check("pin_reset", k[1], core_reset_out);
      src.pin_set(1'b1);
      repeat (5) @(posedge clk_sys);
      check("pin_gpio", !k[1], reset_pin_gpio_out);
    end
  endtask
  task automatic t_bus;
    logic [31:0] q;
    bus(1'b1, 4'h3, 32'he7, q);
    bus(1'b0, 4'h3, 32'h0, q);
    check("status_rd", 32'hff, q);
    bus(1'b1, 4'h3, 32'h0, q);
    bus(1'b0, 4'h3, 32'h0, q);
    check("status_rd", 32'h18, q);
    bus(1'b0, 4'h9, 32'h0, q);
    check("unmapped", 32'h0, q);
    bus(1'b1, 4'h4, 32'h0, q);
    bus(1'b0, 4'h4, 32'h0, q);
    check("config_rd", 32'hfff, q);
    bus(1'b1, 4'h7, 32'h1, q);
    bus(1'b0, 4'h6, 32'h0, q);
    check("timer_rd", 32'h2, q);
    check("soft_reset", 1'b1, core_reset_out);
  endtask
  task automatic t_alu;
    @(posedge clk_sys);
    core_status_we <= 1'b1;
    core_status_wdata <= 8'he0;
    core_alu_we <= 1'b1;
    core_alu_flags <= 3'h5;
    @(posedge clk_sys);
    core_status_we <= 1'b0;
    core_alu_we <= 1'b0;
    @(posedge clk_sys);
    check("status_alu", 8'hfd, status_out);
  endtask
  task automatic t_causes;
    logic [3:0] exp [6] = '{4'h1, 4'ha, 4'h6, 4'h0, 4'h0, 4'h2};
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      core_sleeping <= !(i == 0 || i == 4);
      src.fire(i);
      repeat (2) @(posedge clk_sys);
      check("flags", exp[i], {status_out[7:6], status_out[4:3]});
      check("core_hold", 1'b1, core_reset_out);
    end
    core_sleeping <= 1'b0;
    bus(1'b0, 4'h5, 32'h0, q);
    check("cause_rd", 32'h3, q);
  endtask
  initial begin
    {avs_read, avs_write, core_sleeping, core_status_we, core_alu_we} = 5'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    core_status_wdata = 8'h0;
    core_alu_flags = 3'h0;
    rst_n = 1'b0;
    cfg_word = 12'hfff;
    t_config();
    t_bus();
    t_alu();
    t_causes();
    stop_test();
  end
endmodule
bind status_reset_logic status_reset_checker #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cfg_word(cfg_word), .reset_pin_raw(reset_pin_raw),
  .wdt_timeout(wdt_timeout), .pin_change_wake(pin_change_wake),
  .comp_change_wake(comp_change_wake), .core_sleeping(core_sleeping),
  .core_status_we(core_status_we), .core_alu_we(core_alu_we), .core_alu_flags(core_alu_flags),
  .status_out(status_out), .core_reset_out(core_reset_out),
  .reset_pin_gpio_out(reset_pin_gpio_out), .int_osc_fast_out(int_osc_fast_out),
  .clock_out_en_out(clock_out_en_out), .osc_kind_out(osc_kind_out));

// ==== bench/wake_source_model.sv ====
// Model of the reset pin, watchdog and wake sources
`timescale 1ns/1ps
module wake_source_model (
  input wire logic clk_sys,
  output logic reset_pin_raw,
  output logic wdt_timeout,
  output logic pin_change_wake,
  output logic comp_change_wake
);
  initial begin
    reset_pin_raw = 1'b1;
    {wdt_timeout, pin_change_wake, comp_change_wake} = 3'h0;
  end
  task automatic pin_set(input logic v);
    @(posedge clk_sys);
    reset_pin_raw <= v;
  endtask
  // Codes: 0,3 watchdog, 1 pin change, 2 comparator, 4,5 reset pin
  task automatic fire(input int c);
    @(posedge clk_sys);
    wdt_timeout <= c == 0 || c == 3;
    pin_change_wake <= c == 1;
    comp_change_wake <= c == 2;
    reset_pin_raw <= !(c == 4 || c == 5);
    @(posedge clk_sys);
    {wdt_timeout, pin_change_wake, comp_change_wake} <= 3'h0;
    repeat (5) @(posedge clk_sys);
    reset_pin_raw <= 1'b1;
  endtask
endmodule

// ==== rtl/config_decode.sv ====
// Decoder of the device configuration word
`timescale 1ns/1ps
`include "status_reset_defines.svh"

module config_decode (
  input wire logic [11:0] cfg_word,
  output status_reset_pkg::cfg_decode_t dec
);

  always_comb begin
    dec.osc_kind = cfg_word[2:0];
    // Internal oscillator speed
    dec.int_osc_fast = cfg_word[`CFG_OSC_SPEED];
    dec.reset_pin_enable = cfg_word[`CFG_RST_PIN_EN];
    // Clock output only on the two clock-out variants
    dec.clock_out_en = (cfg_word[2:0] == `OSC_INT_CLOCK_OUTPUT_FUNCTION) ||
                       (cfg_word[2:0] == `OSC_RC_CLOCK_OUTPUT_FUNCTION);
    case (cfg_word[2:0])
      `OSC_LP, `OSC_HS, `OSC_XT: begin
        dec.long_timer = 1'b1;
      end
      default: begin
        dec.long_timer = 1'b0;
      end
    endcase
  end

endmodule

// ==== rtl/reset_timer.sv ====
// Device reset timer with short and long periods
`timescale 1ns/1ps
`include "status_reset_defines.svh"

module reset_timer #(
  parameter int unsigned SHORT_CYC = `DRT_SHORT_CYC,
  parameter int unsigned LONG_CYC = `DRT_LONG_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic long_sel,
  output logic expired
);

  logic [19:0] count_reg;

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 20'h00000;
      expired <= 1'b0;
    end else if (restart) begin
      count_reg <= long_sel ? LONG_CYC[19:0] : SHORT_CYC[19:0];
      expired <= 1'b0;
    end else if (count_reg > 20'h00001) begin
      count_reg <= count_reg - 20'h00001;
    end else begin
      count_reg <= 20'h00000;
      expired <= 1'b1;
    end
  end

endmodule

// ==== rtl/status_reset_defines.svh ====
// Offsets, field positions, reset values and timing counts of the status and reset block
`ifndef STATUS_RESET_DEFINES_SVH
`define STATUS_RESET_DEFINES_SVH

`define CLK_HZ 40000000
`define DRT_SHORT_US 1125
`define DRT_LONG_US 18000
`define DRT_SHORT_CYC ((`DRT_SHORT_US * (`CLK_HZ / 1000000)))
`define DRT_LONG_CYC ((`DRT_LONG_US * (`CLK_HZ / 1000000)))

`define ADDR_STATUS 4'h3
`define ADDR_CONFIG 4'h4
`define ADDR_CAUSE 4'h5
`define ADDR_ALU 4'h6
`define ADDR_CTRL 4'h7

`define STATUS_POR_VAL 8'h18
`define STATUS_PROT_MASK 8'h18
`define STATUS_ARITH_MASK 8'h07

`define BIT_PCWU 7
`define BIT_CWU 6
`define BIT_PAGE 5
`define BIT_TO 4
`define BIT_PD 3
`define BIT_Z 2
`define BIT_DC 1
`define BIT_C 0

`define CFG_OSC_SPEED 6
`define CFG_RST_PIN_EN 5
`define CFG_RESET_VAL 12'hfff

`define OSC_LP 3'h0
`define OSC_HS 3'h1
`define OSC_XT 3'h2
`define OSC_EC 3'h3
`define OSC_INT_IO 3'h4
`define OSC_INT_CLOCK_OUTPUT_FUNCTION 3'h5
`define OSC_RC_IO 3'h6
`define OSC_RC_CLOCK_OUTPUT_FUNCTION 3'h7

`endif

// ==== rtl/status_reset_logic.sv ====
// Status word, reset cause logic and Avalon-MM register slave
// Function
// - Instruction updating Z, DC, C on status keeps results, ignores written bits.
// - Writes never change timeout or power-down flags.
// - Status accepts any write; unprotected bits take the written value.
// - Bit layout pin-wake, comp-wake, page, TO, PD, Z, DC, C; power-on 0001 1xxx.
// - Watchdog wake from sleep clears wake flags, timeout and power-down.
// - Watchdog timeout while running clears wake flags and timeout, keeps power-down.
// - Reset pin wake from sleep clears wake flags, sets timeout, clears power-down.
// - Reset pin while running clears wake flags, keeps timeout and power-down.
// - Pin change wake sets pin wake flag, clears comp flag, sets TO, clears PD.
// - Comparator wake sets comp flag, clears pin flag, sets TO, clears PD.
// - Config bit 6 selects 8 MHz when one, 4 MHz when zero.
// - Config bit 5 enables active-low reset pin; else pin is plain input.
// - Oscillator select field decodes to the eight documented sources.
// - Reset timer runs short period for internal, RC and external clock.
// - Reset timer runs long period for crystal sources.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "status_reset_defines.svh"

module status_reset_logic #(
  parameter int unsigned SHORT_CYC = `DRT_SHORT_CYC,
  parameter int unsigned LONG_CYC = `DRT_LONG_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [11:0] cfg_word,
  input wire logic reset_pin_raw,
  input wire logic wdt_timeout,
  input wire logic pin_change_wake,
  input wire logic comp_change_wake,
  input wire logic core_sleeping,
  input wire logic core_status_we,
  input wire logic [7:0] core_status_wdata,
  input wire logic core_alu_we,
  input wire status_reset_pkg::alu_flags_t core_alu_flags,
  output logic [7:0] status_out,
  output logic core_reset_out,
  output logic reset_pin_gpio_out,
  output logic int_osc_fast_out,
  output logic clock_out_en_out,
  output logic [2:0] osc_kind_out
);

  status_reset_pkg::cfg_decode_t dec;
  status_reset_pkg::cause_t cause;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [11:0] cfg_reg;
  logic [11:0] cfg_cur;
  logic cfg_loaded_reg;
  logic pin_sync1_reg;
  logic pin_sync2_reg;
  logic pin_low_prev_reg;
  logic reset_pin_low;
  logic pin_fall;
  logic timer_restart;
  logic timer_expired;
  logic hold_reg;
  logic sw_reset_reg;
  logic [2:0] last_cause_reg;
  logic ack_reg;
  logic bus_we;
  logic [7:0] bus_wdata;

  // ----------------------------------------
  // Configuration capture and decode
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `CFG_RESET_VAL;
      cfg_loaded_reg <= 1'b0;
    end else if (!cfg_loaded_reg) begin
      cfg_reg <= cfg_word;
      cfg_loaded_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Decoder input
  // ----------------------------------------
  // Live word until captured, so the first timer load sees the real source
  assign cfg_cur = cfg_loaded_reg ? cfg_reg : cfg_word;

  config_decode u_decode (
    .cfg_word(cfg_cur),
    .dec(dec)
  );

  // ----------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync1_reg <= 1'b1;
      pin_sync2_reg <= 1'b1;
      pin_low_prev_reg <= 1'b0;
    end else begin
      pin_sync1_reg <= reset_pin_raw;
      pin_sync2_reg <= pin_sync1_reg;
      pin_low_prev_reg <= reset_pin_low;
    end
  end

  // Pin acts as reset only when enabled, otherwise reset tied inactive
  assign reset_pin_low = dec.reset_pin_enable && !pin_sync2_reg;
  assign pin_fall = reset_pin_low && !pin_low_prev_reg;

  // ----------------------------------------
  // Cause priority
  // ----------------------------------------
  always_comb begin
    if (pin_fall) begin
      cause = core_sleeping ? status_reset_pkg::CAUSE_PIN_SLEEP
                            : status_reset_pkg::CAUSE_PIN_RUN;
    end else if (wdt_timeout) begin
      cause = core_sleeping ? status_reset_pkg::CAUSE_WDT_SLEEP
                            : status_reset_pkg::CAUSE_WDT_RUN;
    end else if (core_sleeping && pin_change_wake) begin
      cause = status_reset_pkg::CAUSE_CHANGE_WAKE;
    end else if (core_sleeping && comp_change_wake) begin
      cause = status_reset_pkg::CAUSE_COMP_WAKE;
    end else begin
      cause = status_reset_pkg::CAUSE_NONE;
    end
  end

  // ----------------------------------------
  // Status next value
  // ----------------------------------------
  assign bus_we = avs_write && ack_reg && (avs_address == `ADDR_STATUS);
  assign bus_wdata = avs_writedata[7:0];

  always_comb begin
    status_next = status_reg;
    if (core_status_we) begin
      status_next = (status_reg & `STATUS_PROT_MASK) |
                    (core_status_wdata & ~`STATUS_PROT_MASK);
    end else if (bus_we) begin
      status_next = (status_reg & `STATUS_PROT_MASK) |
                    (bus_wdata & ~`STATUS_PROT_MASK);
    end
    if (core_alu_we) begin
      status_next[`BIT_Z] = core_alu_flags.z;
      status_next[`BIT_DC] = core_alu_flags.dc;
      status_next[`BIT_C] = core_alu_flags.c;
    end
    case (cause)
      status_reset_pkg::CAUSE_WDT_SLEEP: begin
        status_next[`BIT_PCWU] = 1'b0;
        status_next[`BIT_CWU] = 1'b0;
        status_next[`BIT_TO] = 1'b0;
        status_next[`BIT_PD] = 1'b0;
      end
      status_reset_pkg::CAUSE_WDT_RUN: begin
        status_next[`BIT_PCWU] = 1'b0;
        status_next[`BIT_CWU] = 1'b0;
        status_next[`BIT_TO] = 1'b0;
      end
      status_reset_pkg::CAUSE_PIN_SLEEP: begin
        status_next[`BIT_PCWU] = 1'b0;
        status_next[`BIT_CWU] = 1'b0;
        status_next[`BIT_TO] = 1'b1;
        status_next[`BIT_PD] = 1'b0;
      end
      status_reset_pkg::CAUSE_PIN_RUN: begin
        status_next[`BIT_PCWU] = 1'b0;
        status_next[`BIT_CWU] = 1'b0;
      end
      status_reset_pkg::CAUSE_CHANGE_WAKE: begin
        status_next[`BIT_PCWU] = 1'b1;
        status_next[`BIT_CWU] = 1'b0;
        status_next[`BIT_TO] = 1'b1;
        status_next[`BIT_PD] = 1'b0;
      end
      status_reset_pkg::CAUSE_COMP_WAKE: begin
        status_next[`BIT_PCWU] = 1'b0;
        status_next[`BIT_CWU] = 1'b1;
        status_next[`BIT_TO] = 1'b1;
        status_next[`BIT_PD] = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= `STATUS_POR_VAL;
    end else begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------
  // Reset hold and timer
  // ----------------------------------------
  assign timer_restart = !cfg_loaded_reg || reset_pin_low || sw_reset_reg ||
                         (cause != status_reset_pkg::CAUSE_NONE);

  reset_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .restart(timer_restart),
    .long_sel(dec.long_timer),
    .expired(timer_expired)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 1'b1;
    end else begin
      hold_reg <= timer_restart || !timer_expired;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_cause_reg <= 3'h0;
    end else if (cause != status_reset_pkg::CAUSE_NONE) begin
      last_cause_reg <= cause;
    end
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if (avs_read && !ack_reg) begin
        case (avs_address)
          `ADDR_STATUS: avs_readdata <= {24'h000000, status_reg};
          `ADDR_CONFIG: avs_readdata <= {20'h00000, cfg_reg};
          `ADDR_CAUSE: avs_readdata <= {29'h00000000, last_cause_reg};
          `ADDR_ALU: avs_readdata <= {30'h00000000, hold_reg, timer_expired};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Wait state, low in the second cycle of a request
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sw_reset_reg <= 1'b0;
    end else begin
      sw_reset_reg <= avs_write && ack_reg && (avs_address == `ADDR_CTRL) &&
                      avs_writedata[0];
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_out <= `STATUS_POR_VAL;
      core_reset_out <= 1'b1;
      reset_pin_gpio_out <= 1'b0;
      int_osc_fast_out <= 1'b1;
      clock_out_en_out <= 1'b1;
      osc_kind_out <= 3'h7;
    end else begin
      status_out <= status_next;
      core_reset_out <= hold_reg;
      reset_pin_gpio_out <= !dec.reset_pin_enable && pin_sync2_reg;
      int_osc_fast_out <= dec.int_osc_fast;
      clock_out_en_out <= dec.clock_out_en;
      osc_kind_out <= dec.osc_kind;
    end
  end

endmodule

// ==== rtl/status_reset_pkg.sv ====
// Types shared by the status and reset block
package status_reset_pkg;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_WDT_SLEEP,
    CAUSE_WDT_RUN,
    CAUSE_PIN_SLEEP,
    CAUSE_PIN_RUN,
    CAUSE_CHANGE_WAKE,
    CAUSE_COMP_WAKE
  } cause_t;

  typedef struct packed {
    logic [2:0] osc_kind;
    logic clock_out_en;
    logic int_osc_fast;
    logic reset_pin_enable;
    logic long_timer;
  } cfg_decode_t;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } alu_flags_t;

endpackage
